// ===== rtl/sbci_top.sv
// Processor-facing register bank of the subscriber buffer
`default_nettype none
module sbci_top (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // Processor register port
  input  wire logic [15:0]          cpu_addr,
  input  wire logic                 cpu_rd,
  input  wire logic                 cpu_wr,
  input  wire logic [15:0]          cpu_wdata,
  output logic [15:0]               cpu_rdata,
  // Jump conditions, flags and initialization
  output logic                      msg_transmitted_cond,
  output logic                      terminal_break_cond,
  output logic                      msg_received_cond,
  input  wire logic [3:0]           proc_flags,
  output logic                      init_req,
  // Keypad control unit
  input  wire logic                 kp_load,
  input  wire sbci_pkg::sbci_setup_s kp_setup,
  // Cable receive
  input  wire logic                 rx_valid,
  input  wire sbci_pkg::sbci_rx_s   rx_byte,
  // Cable transmit
  input  wire logic                 tx_poll,
  output logic                      tx_valid,
  output logic [7:0]                tx_data,
  output logic                      tx_last,
  // Terminal
  input  wire logic                 term_char_valid,
  input  wire logic [7:0]           term_char,
  input  wire logic                 term_break_key,
  output logic                      term_hold,
  output logic                      term_break,
  output logic                      term_out_valid,
  input  wire logic                 term_out_ready,
  output logic [7:0]                term_out_data
);
  import sbci_pkg::*;

  function automatic logic hit(input logic stb, input logic [15:0] a,
                               input logic [15:0] off);
    return stb && (a == off);
  endfunction : hit

  logic [ADDR_BITS-1:0] rx_addr_r;
  logic [ADDR_BITS-1:0] tx_addr_r;
  logic                 init_r;
  logic [15:0]          rdata_r;
  logic [3:0]           flg_q_r;
  logic [3:0]           flg_rise;
  logic [7:0]           in_buf [MSG_BYTES];
  logic [7:0]           out_buf [MSG_BYTES];
  logic [3:0]           rx_cnt_r;
  logic                 rx_long_r;
  logic [3:0]           rd_idx_r;
  logic [3:0]           wr_idx_r;
  logic [3:0]           tx_cnt_r;
  sbci_tx_e             tx_st_r;
  logic                 out_ok_r;
  logic                 dummy_r;
  logic                 xmit_r;
  logic                 recv_r;
  logic                 brk_r;
  logic                 tx_valid_r;
  logic [7:0]           tx_data_r;
  logic                 tx_last_r;
  logic [7:0]           tc_char_r;
  logic                 tc_rdy_r;
  logic                 ct_rdy_r;
  logic                 ct_in_ready;
  logic                 hold_r;
  logic                 tbrk_r;
  logic                 rx_rd;
  logic                 tc_rd;
  logic                 cor_wr;
  logic                 ct_wr;
  logic                 hdr_wr;
  logic                 emerg_wr;
  logic                 msg_done;
  logic                 tx_done;
  logic                 rx_good;
  logic                 addr_live;

  assign rx_rd    = hit(cpu_rd, cpu_addr, ADDR_CABLE_RX);
  assign tc_rd    = hit(cpu_rd, cpu_addr, ADDR_TC_CHAR);
  assign cor_wr   = hit(cpu_wr, cpu_addr, ADDR_CABLE_TX);
  assign ct_wr    = hit(cpu_wr, cpu_addr, ADDR_CT_CHAR);
  assign hdr_wr   = cor_wr && (wr_idx_r == MSG_FIRST);
  assign emerg_wr = hdr_wr && cpu_wdata[HDR_RETX_SENT_BIT];
  assign msg_done = emerg_wr || (cor_wr && (wr_idx_r == MSG_LAST));
  assign tx_done  = (tx_st_r == TX_SEND) && (tx_cnt_r == MSG_LAST);
  assign addr_live = (|rx_addr_r) || (|tx_addr_r);
  assign rx_good  = rx_valid && rx_byte.last && rx_byte.parity_ok &&
                    (rx_cnt_r == MSG_LAST) && !rx_long_r && addr_live;

  assign cpu_rdata            = rdata_r;
  assign msg_transmitted_cond = xmit_r;
  assign terminal_break_cond  = brk_r;
  assign msg_received_cond    = recv_r;
  assign init_req             = init_r;
  assign tx_valid             = tx_valid_r;
  assign tx_data              = tx_data_r;
  assign tx_last              = tx_last_r;
  assign term_hold            = hold_r;
  assign term_break           = tbrk_r;

  //////////////////////////////////////////////////////////////////////////
  // Processor flag edge detection

  genvar g;
  generate
    for (g = 0; g < FLG_COUNT; g++) begin : g_rise
      assign flg_rise[g] = proc_flags[g] && !flg_q_r[g];
    end
  endgenerate

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flg_q_r <= 4'h0;
    end else begin
      flg_q_r <= proc_flags;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Keypad setup

  // Low ten bits of third word
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_addr_r <= '0;
      tx_addr_r <= '0;
      init_r    <= 1'b0;
    end else begin
      init_r <= kp_load;
      if (kp_load) begin
        rx_addr_r <= kp_setup.rx_addr;
        tx_addr_r <= kp_setup.tx_word[ADDR_BITS-1:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Register read port

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_r <= RDATA_RESET;
    end else if (cpu_rd) begin
      case (cpu_addr)
        ADDR_CABLE_RX:  rdata_r <= {8'h00, in_buf[rd_idx_r]};
        ADDR_TC_CHAR:   rdata_r <= {8'h00, tc_char_r};
        ADDR_TC_RDY:    rdata_r <= {tc_rdy_r, 15'h0000};
        ADDR_CT_RDY:    rdata_r <= {ct_rdy_r, 15'h0000};
        ADDR_PEER_ADDR: rdata_r <= {6'h00, tx_addr_r};
        default:        rdata_r <= RDATA_RESET;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Cable receive buffer

  always_ff @(posedge clk) begin
    if (rx_valid) begin
      in_buf[rx_cnt_r] <= rx_byte.data;
    end
  end

  // Overlong messages pile into the last slot and fail the length check
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rx_cnt_r  <= MSG_FIRST;
      rx_long_r <= 1'b0;
    end else if (rx_valid) begin
      if (rx_byte.last) begin
        rx_cnt_r  <= MSG_FIRST;
        rx_long_r <= 1'b0;
      end else if (rx_cnt_r != MSG_LAST) begin
        rx_cnt_r <= rx_cnt_r + 4'h1;
      end else begin
        rx_long_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_idx_r <= MSG_FIRST;
    end else if (rx_good) begin
      rd_idx_r <= MSG_FIRST;
    end else if (rx_rd) begin
      if (rd_idx_r == MSG_FIRST) begin
        rd_idx_r <= MSG_AFTER;
      end else if (rd_idx_r != MSG_LAST) begin
        rd_idx_r <= rd_idx_r + 4'h1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      recv_r <= 1'b0;
    end else if (rx_good) begin
      recv_r <= 1'b1;
    end else if (flg_rise[FLG_RX_ACK] || kp_load) begin
      recv_r <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Cable transmit buffer

  always_ff @(posedge clk) begin
    if (cor_wr) begin
      out_buf[wr_idx_r] <= cpu_wdata[7:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_idx_r <= MSG_FIRST;
    end else if (kp_load || msg_done) begin
      wr_idx_r <= MSG_FIRST;
    end else if (cor_wr) begin
      wr_idx_r <= wr_idx_r + 4'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_ok_r <= 1'b0;
      dummy_r  <= 1'b0;
    end else begin
      if (kp_load || (hdr_wr && !emerg_wr)) begin
        out_ok_r <= 1'b0;
      end else if (msg_done) begin
        out_ok_r <= 1'b1;
      end
      if (hdr_wr) begin
        dummy_r <= cpu_wdata[HDR_SIMPLEX_BIT];
      end
    end
  end

  // Held message is resent on every poll until replaced or cleared by a keypad load, unless its header has bit 2 set
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_st_r  <= TX_IDLE;
      tx_cnt_r <= MSG_FIRST;
    end else begin
      unique case (tx_st_r)
        TX_IDLE: begin
          tx_cnt_r <= MSG_FIRST;
          if (tx_poll && out_ok_r && !dummy_r) begin
            tx_st_r <= TX_SEND;
          end
        end
        TX_SEND: begin
          tx_cnt_r <= tx_cnt_r + 4'h1;
          if (tx_done) begin
            tx_st_r <= TX_IDLE;
          end
        end
        default: tx_st_r <= TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_valid_r <= 1'b0;
      tx_data_r  <= 8'h00;
      tx_last_r  <= 1'b0;
    end else begin
      tx_valid_r <= (tx_st_r == TX_SEND);
      tx_last_r  <= tx_done;
      if (tx_st_r == TX_SEND) begin
        tx_data_r <= out_buf[tx_cnt_r];
      end
    end
  end

  // Set after sending, clear on emergency header
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      xmit_r <= 1'b0;
    end else if (tx_done) begin
      xmit_r <= 1'b1;
    end else if (emerg_wr) begin
      xmit_r <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Terminal side

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tc_char_r <= 8'h00;
      tc_rdy_r  <= 1'b0;
    end else if (term_char_valid) begin
      tc_char_r <= term_char;
      tc_rdy_r  <= 1'b1;
    end else if (tc_rd) begin
      tc_rdy_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ct_rdy_r <= 1'b0;
    end else if (ct_wr) begin
      ct_rdy_r <= 1'b0;
    end else begin
      ct_rdy_r <= ct_in_ready;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      brk_r <= 1'b0;
    end else if (term_break_key) begin
      brk_r <= 1'b1;
    end else if (flg_rise[FLG_TC_ACK]) begin
      brk_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tbrk_r <= 1'b0;
      hold_r <= 1'b0;
    end else begin
      tbrk_r <= flg_rise[FLG_CT_BREAK];
      hold_r <= proc_flags[FLG_HOLDUP];
    end
  end

  // Full queue drops the ready flag, so software stalls instead of losing data
  sbci_fifo #(
    .WIDTH (CT_FIFO_WIDTH),
    .DEPTH (CT_FIFO_DEPTH)
  ) u_ct_queue (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (ct_wr),
    .in_ready  (ct_in_ready),
    .in_data   (cpu_wdata[7:0]),
    .out_valid (term_out_valid),
    .out_ready (term_out_ready),
    .out_data  (term_out_data)
  );
endmodule : sbci_top
`default_nettype wire

// ===== rtl/sbci_pkg.sv
// Constants and carrier types for the subscriber buffer processor interface
`default_nettype none
package sbci_pkg;
  // Processor register addresses and read data reset value
  localparam logic [15:0] ADDR_CABLE_RX   = 16'h8001;
  localparam logic [15:0] ADDR_CABLE_TX   = 16'h8002;
  localparam logic [15:0] ADDR_TC_CHAR    = 16'h8003;
  localparam logic [15:0] ADDR_TC_RDY     = 16'h8004;
  localparam logic [15:0] ADDR_CT_CHAR    = 16'h8005;
  localparam logic [15:0] ADDR_CT_RDY     = 16'h8006;
  localparam logic [15:0] ADDR_PEER_ADDR  = 16'h8007;
  localparam logic [15:0] RDATA_RESET     = 16'h0000;

  // Header bit positions and ready flag position
  localparam int HDR_RETX_SENT_BIT = 4;
  localparam int HDR_SIMPLEX_BIT   = 2;
  localparam int RDY_BIT           = 15;

  // Message layout: two header bytes then eight data bytes
  localparam logic [3:0] MSG_FIRST   = 4'h0;
  localparam logic [3:0] MSG_SKIPPED = 4'h1;
  localparam logic [3:0] MSG_AFTER   = 4'h2;
  localparam logic [3:0] MSG_LAST    = 4'h9;
  localparam int         MSG_BYTES   = 10;
  localparam int         ADDR_BITS   = 10;

  // Processor flag positions in proc_flags
  localparam int FLG_HOLDUP   = 0;
  localparam int FLG_CT_BREAK = 1;
  localparam int FLG_TC_ACK   = 2;
  localparam int FLG_RX_ACK   = 3;
  localparam int FLG_COUNT    = 4;

  // Cable-to-terminal queue shape
  localparam int CT_FIFO_WIDTH = 8;
  localparam int CT_FIFO_DEPTH = 16;

  typedef struct packed {
    logic [ADDR_BITS-1:0] rx_addr;
    logic [15:0]          tx_word;
  } sbci_setup_s;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
    logic       parity_ok;
  } sbci_rx_s;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SEND = 2'b10
  } sbci_tx_e;
endpackage : sbci_pkg
`default_nettype wire

// ===== rtl/sbci_fifo.sv
// Parameterised valid/ready FIFO for the cable-to-terminal queue
`default_nettype none
module sbci_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW:0]      wp_r;
  logic [PW:0]      rp_r;
  logic             push;
  logic             pop;

  assign in_ready  = (wp_r - rp_r) != (PW+1)'(DEPTH);
  assign out_valid = wp_r != rp_r;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_r[rp_r[PW-1:0]];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wp_r[PW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
    end
  end
endmodule : sbci_fifo
`default_nettype wire

// ===== bench/sbci_chk.sv
// Assertion checker for the subscriber buffer processor interface
`default_nettype none
module sbci_chk
  import sbci_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // Register port
  input wire logic [15:0] cpu_addr,
  input wire logic        cpu_rd,
  input wire logic [15:0] cpu_rdata,
  // Conditions and flags
  input wire logic [3:0]  proc_flags,
  input wire logic        kp_load,
  input wire logic        init_req,
  input wire logic        rx_valid,
  input wire logic        msg_received_cond,
  input wire logic        msg_transmitted_cond,
  input wire logic        terminal_break_cond,
  // Terminal and cable
  input wire logic        term_break_key,
  input wire logic        term_hold,
  input wire logic        term_break,
  input wire logic        tx_valid,
  input wire logic        tx_last
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////
  init_pulse_a: assert property (kp_load |=> init_req ##1 !init_req)
    else $error("init request is not a single pulse");
  tc_rdy_fmt_a: assert property (cpu_rd && cpu_addr == ADDR_TC_RDY |=>
    cpu_rdata[14:0] == 15'h0000) else $error("unused bits set in tc ready");
  ct_rdy_fmt_a: assert property (cpu_rd && cpu_addr == ADDR_CT_RDY |=>
    cpu_rdata[14:0] == 15'h0000) else $error("unused bits set in ct ready");
  hold_follow_a: assert property ($rose(proc_flags[FLG_HOLDUP]) |=> term_hold)
    else $error("terminal not held");
  line_break_a: assert property ($rose(proc_flags[FLG_CT_BREAK]) |=>
    term_break ##1 !term_break) else $error("line break pulse wrong");
  break_set_a: assert property (term_break_key |=> terminal_break_cond)
    else $error("break condition not raised");
  break_clear_a: assert property ($rose(proc_flags[FLG_TC_ACK]) && !term_break_key
    |=> !terminal_break_cond) else $error("break condition not cleared");
  rx_ack_clear_a: assert property ($rose(proc_flags[FLG_RX_ACK]) && !rx_valid
    |=> !msg_received_cond) else $error("received condition not cleared");
  tx_burst_a: assert property ($rose(tx_valid) |-> ##9 (tx_valid && tx_last)
    ##1 !tx_valid) else $error("transmit burst length wrong");
  tx_flag_a: assert property (tx_last |-> msg_transmitted_cond)
    else $error("transmitted condition missing at last byte");

  cover property ($rose(msg_received_cond));
  cover property (tx_last);
  cover property (term_break);
endmodule : sbci_chk

bind sbci_top sbci_chk u_chk (.clk, .rst, .cpu_addr, .cpu_rd, .cpu_rdata, .proc_flags,
  .kp_load, .init_req, .rx_valid, .msg_received_cond, .msg_transmitted_cond,
  .terminal_break_cond, .term_break_key, .term_hold, .term_break, .tx_valid, .tx_last);
`default_nettype wire

// ===== bench/sbci_cpu_model.sv
// Processor model driving register strobes and flag lines
`default_nettype none
module sbci_cpu_model (
  // Clock
  input  wire logic        clk,
  // Register port
  output var  logic [15:0] cpu_addr,
  output var  logic        cpu_rd,
  output var  logic        cpu_wr,
  output var  logic [15:0] cpu_wdata,
  input  wire logic [15:0] cpu_rdata,
  // Flags
  output var  logic [3:0]  proc_flags
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cpu_addr = 16'h0000;
    cpu_rd = 1'b0;
    cpu_wr = 1'b0;
    cpu_wdata = 16'h0000;
    proc_flags = 4'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Released lines invert so a stale value never looks valid
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk);
    cpu_rd <= 1'b1;
    cpu_addr <= a;
    @(posedge clk);
    cpu_rd <= 1'b0;
    cpu_addr <= ~a;
    #1;
    d = cpu_rdata;
  endtask : rd

  task automatic wr(input logic [15:0] a, input logic [7:0] b);
    @(posedge clk);
    cpu_wr <= 1'b1;
    cpu_addr <= a;
    cpu_wdata <= {8'h00, b};
    @(posedge clk);
    cpu_wr <= 1'b0;
    cpu_addr <= ~a;
    cpu_wdata <= ~{8'h00, b};
  endtask : wr

  task automatic flag(input int unsigned idx, input logic v);
    @(posedge clk);
    proc_flags[idx] <= v;
  endtask : flag
endmodule : sbci_cpu_model
`default_nettype wire

// ===== bench/sbci_top_tb.sv
// Self-checking bench for the subscriber buffer processor interface
`default_nettype none
module sbci_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sbci_pkg::*;
  logic        clk, rst, cpu_rd, cpu_wr, kp_load, rx_valid, tx_poll, tx_valid, tx_last;
  logic        msg_transmitted_cond, terminal_break_cond, msg_received_cond, init_req;
  logic        term_char_valid, term_break_key, term_hold, term_break;
  logic        term_out_valid, term_out_ready;
  logic [15:0] cpu_addr, cpu_wdata, cpu_rdata;
  logic [7:0]  tx_data, term_char, term_out_data;
  logic [3:0]  proc_flags;
  sbci_setup_s kp_setup;
  sbci_rx_s    rx_byte;
  logic [7:0]  txq[$];
  int          num_errors = 0;
  int          samples_checked = 0;

  sbci_top u_dut (.clk, .rst, .cpu_addr, .cpu_rd, .cpu_wr, .cpu_wdata, .cpu_rdata,
    .msg_transmitted_cond, .terminal_break_cond, .msg_received_cond, .proc_flags,
    .init_req, .kp_load, .kp_setup, .rx_valid, .rx_byte, .tx_poll, .tx_valid, .tx_data,
    .tx_last, .term_char_valid, .term_char, .term_break_key, .term_hold, .term_break,
    .term_out_valid, .term_out_ready, .term_out_data);
  sbci_cpu_model u_cpu (.clk, .cpu_addr, .cpu_rd, .cpu_wr, .cpu_wdata, .cpu_rdata,
    .proc_flags);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rchk(input logic [15:0] a, input logic [15:0] exp);
    logic [15:0] d;
    u_cpu.rd(a, d);
    chk(d, exp);
  endtask : rchk

  task automatic send_msg(input logic [7:0] base, input logic ok, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_byte <= '{data: base + 8'(i), last: logic'(i == n - 1), parity_ok: ok};
    end
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_byte <= ~rx_byte;
    @(posedge clk);
    #1;
  endtask : send_msg

  // Header alone when bit 4 is set, else header and nine bytes
  task automatic put_msg(input logic [7:0] hdr, input logic [7:0] base);
    u_cpu.wr(ADDR_CABLE_TX, hdr);
    if (!hdr[HDR_RETX_SENT_BIT]) begin
      for (int k = 1; k < MSG_BYTES; k++) u_cpu.wr(ADDR_CABLE_TX, base + 8'(k));
    end
  endtask : put_msg

  task automatic poll_chk(input int n, input logic [7:0] hdr, input logic [7:0] base);
    int last_at;
    txq = {};
    last_at = 0;
    @(posedge clk);
    tx_poll <= 1'b1;
    @(posedge clk);
    tx_poll <= 1'b0;
    repeat (16) begin
      @(posedge clk);
      #1;
      if (tx_valid === 1'b1) txq.push_back(tx_data);
      if (tx_last === 1'b1) last_at = txq.size();
    end
    chk(16'(txq.size()), 16'(n));
    chk(16'(last_at), 16'(n));
    for (int k = 0; k < txq.size(); k++) begin
      chk({8'h00, txq[k]}, {8'h00, k == 0 ? hdr : base + 8'(k)});
    end
  endtask : poll_chk

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : wrap_up

  initial begin
    #100us;
    num_errors++;
    wrap_up();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    {kp_load, rx_valid, tx_poll, term_char_valid, term_break_key, term_out_ready} = '0;
    kp_setup = '0;
    rx_byte = '0;
    term_char = 8'h00;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rchk(ADDR_TC_RDY, 16'h0000);
    rchk(ADDR_CT_RDY, 16'h8000);
    rchk(ADDR_PEER_ADDR, 16'h0000);
    rchk(16'h8000, RDATA_RESET);
    send_msg(8'h10, 1'b1, MSG_BYTES);
    chk({15'h0000, msg_received_cond}, 16'h0000);
    @(posedge clk);
    kp_load <= 1'b1;
    kp_setup <= '{rx_addr: 10'h001, tx_word: 16'hfc05};
    @(posedge clk);
    kp_load <= 1'b0;
    #1;
    chk({15'h0000, init_req}, 16'h0001);
    rchk(ADDR_PEER_ADDR, 16'h0005);
    send_msg(8'h10, 1'b0, MSG_BYTES);
    chk({15'h0000, msg_received_cond}, 16'h0000);
    // Eleven bytes must not pass as a message
    send_msg(8'h10, 1'b1, MSG_BYTES + 1);
    chk({15'h0000, msg_received_cond}, 16'h0000);
    send_msg(8'h10, 1'b1, MSG_BYTES);
    chk({15'h0000, msg_received_cond}, 16'h0001);
    for (int i = 0; i < 9; i++) begin
      rchk(ADDR_CABLE_RX, i == 0 ? 16'h0010 : 16'h0011 + 16'(i));
    end
    u_cpu.flag(FLG_RX_ACK, 1'b1);
    u_cpu.flag(FLG_RX_ACK, 1'b0);
    @(posedge clk);
    #1;
    chk({15'h0000, msg_received_cond}, 16'h0000);
    put_msg(8'h00, 8'ha0);
    poll_chk(10, 8'h00, 8'ha0);
    chk({15'h0000, msg_transmitted_cond}, 16'h0001);
    put_msg(8'h13, 8'h00);
    @(posedge clk);
    #1;
    chk({15'h0000, msg_transmitted_cond}, 16'h0000);
    poll_chk(10, 8'h13, 8'ha0);
    put_msg(8'h04, 8'hb0);
    poll_chk(0, 8'h04, 8'hb0);
    @(posedge clk);
    term_char_valid <= 1'b1;
    term_char <= 8'h5a;
    @(posedge clk);
    term_char_valid <= 1'b0;
    term_char <= 8'ha5;
    rchk(ADDR_TC_RDY, 16'h8000);
    rchk(ADDR_TC_CHAR, 16'h005a);
    rchk(ADDR_TC_RDY, 16'h0000);
    for (int k = 0; k < CT_FIFO_DEPTH; k++) u_cpu.wr(ADDR_CT_CHAR, 8'h41 + 8'(k));
    rchk(ADDR_CT_RDY, 16'h0000);
    @(posedge clk);
    term_out_ready <= 1'b1;
    for (int k = 0; k < CT_FIFO_DEPTH; k++) begin
      #1;
      chk({7'h00, term_out_valid, term_out_data}, {8'h01, 8'h41 + 8'(k)});
      @(posedge clk);
    end
    term_out_ready <= 1'b0;
    #1;
    chk({15'h0000, term_out_valid}, 16'h0000);
    rchk(ADDR_CT_RDY, 16'h8000);
    @(posedge clk);
    term_break_key <= 1'b1;
    @(posedge clk);
    term_break_key <= 1'b0;
    @(posedge clk);
    #1;
    chk({15'h0000, terminal_break_cond}, 16'h0001);
    u_cpu.flag(FLG_TC_ACK, 1'b1);
    u_cpu.flag(FLG_TC_ACK, 1'b0);
    @(posedge clk);
    #1;
    chk({15'h0000, terminal_break_cond}, 16'h0000);
    u_cpu.flag(FLG_CT_BREAK, 1'b1);
    u_cpu.flag(FLG_CT_BREAK, 1'b0);
    #1;
    chk({15'h0000, term_break}, 16'h0001);
    u_cpu.flag(FLG_HOLDUP, 1'b1);
    @(posedge clk);
    #1;
    chk({15'h0000, term_hold}, 16'h0001);
    u_cpu.flag(FLG_HOLDUP, 1'b0);
    repeat (3) @(posedge clk);
    wrap_up();
  end
endmodule : sbci_top_tb
`default_nettype wire
